//--- logic/remote_trigger_readout_ctrl.sv
// Remote trigger, readout routing and limit pass/fail pulse controller
// Functional notes
// R1: Remote control comes over USB or an optional GPIB port, chosen by a setting.
// R2: With USB off and GPIB chosen, pass/fail outputs replace USB on its contacts.
// R3: Turning USB off enables the pass/fail outputs with no other step.
// R4: Pass and fail are active low and belong to the next reading output.
// R5: Each reading holds its pass or fail line low for about 2 ms, then releases.
// R6: Pass goes on data-minus, fail on data-plus, bus power floats.
// R7: A measure query configures, measures once and puts the result out.
// R8: A configure command only applies settings; measuring waits for read/initiate.
// R9: A read query moves the trigger system from idle to wait-for-trigger.
// R10: After read, each triggered result goes straight to the output buffer.
// R11: The host drains the output buffer; measuring stalls while it is full.
// R12: Read-mode readings bypass and never enter the reading memory.
// R13: Initiate measures on trigger and keeps results in the reading memory.
// R14: A fetch query moves stored readings to the output buffer.
// R15: Triggers are taken only in wait-for-trigger and ignored otherwise.
// R16: Stored readings leave in first-in, first-out order.
`timescale 1ns/10ps
`include "trig_readout_consts.svh"
module remote_trigger_readout_ctrl #(
   parameter int RDG_W = `RDG_WIDTH,
   parameter int OUT_DEPTH = `FIFO_DEPTH,
   parameter int MEM_DEPTH = `MEM_DEPTH,
   parameter int PULSE_CYC = `PF_PULSE_CYC
)
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Interface selection
   input wire logic i_gpib_sel,
   // Command port
   input wire logic i_cmd_valid,
   input wire logic [`CMD_W-1:0] i_cmd,
   input wire trig_readout_pkg::meas_cfg_t i_cmd_cfg,
   output logic o_cmd_ready,
   // Trigger source (external pin)
   input wire logic i_trigger,
   // Measurement engine
   output logic o_meas_start,
   output trig_readout_pkg::meas_cfg_t o_meas_cfg,
   input wire logic i_meas_done,
   input wire trig_readout_pkg::reading_t i_meas_rdg,
   // Output buffer toward remote interface
   output logic o_out_valid,
   output trig_readout_pkg::reading_t o_out_rdg,
   input wire logic i_out_ready,
   // Status
   output trig_readout_pkg::trig_state_t o_state,
   output logic [$clog2(MEM_DEPTH):0] o_mem_count,
   // Interface and USB contacts
   output logic o_usb_en,
   output logic o_dm_out,
   output logic o_dm_oe,
   output logic o_dp_out,
   output logic o_dp_oe,
   output logic o_vbus_oe
);
   localparam int RW = $bits(trig_readout_pkg::reading_t);
   localparam int MAW = $clog2(MEM_DEPTH);
   localparam int PCW = $clog2(PULSE_CYC + 1);

   initial
   begin
      if (RDG_W != 24)
         $error("RDG_W must match reading_t");
      if (MEM_DEPTH < 2 || (1 << MAW) != MEM_DEPTH)
         $error("MEM_DEPTH must be a power of two >= 2");
      if (PULSE_CYC < 1)
         $error("PULSE_CYC must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] trig_sync_reg;
   logic [1:0] gpib_sync_reg;
   logic trig_prev_reg;
   logic trig_edge;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trig_sync_reg <= 2'h0;
         gpib_sync_reg <= 2'h0;
         trig_prev_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         trig_sync_reg <= {trig_sync_reg[0], i_trigger};
         gpib_sync_reg <= {gpib_sync_reg[0], i_gpib_sel};
         trig_prev_reg <= trig_sync_reg[1];
      end
   end
   assign trig_edge = trig_sync_reg[1] && !trig_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // Command decode and trigger state machine
   trig_readout_pkg::trig_state_t state_reg;
   trig_readout_pkg::dest_t dest_reg;
   trig_readout_pkg::meas_cfg_t cfg_reg;
   logic one_shot_reg;
   logic cmd_take;
   logic fifo_in_ready;
   logic fifo_in_valid;
   trig_readout_pkg::reading_t fifo_in_data;
   trig_readout_pkg::reading_t rdg_reg;
   logic mem_full;
   logic mem_empty;

   assign o_cmd_ready = (state_reg == trig_readout_pkg::ST_IDLE)
      || (i_cmd == `CMD_ABORT);
   assign cmd_take = i_ce && i_cmd_valid && o_cmd_ready;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cfg_reg <= '0;
      else if (cmd_take && (i_cmd == `CMD_MEASURE
         || i_cmd == `CMD_CONFIGURE))
         cfg_reg <= i_cmd_cfg; // R7 R8
   end
   assign o_meas_cfg = cfg_reg;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_reg <= trig_readout_pkg::ST_IDLE;
         dest_reg <= trig_readout_pkg::DEST_OUTBUF;
         one_shot_reg <= 1'b0;
         rdg_reg <= '0;
      end
      else if (i_ce)
      begin
         if (cmd_take && i_cmd == `CMD_ABORT)
            state_reg <= trig_readout_pkg::ST_IDLE;
         else
         begin
            unique case (state_reg)
               trig_readout_pkg::ST_IDLE:
               begin
                  if (cmd_take)
                  begin
                     unique case (i_cmd)
                        `CMD_MEASURE:
                        begin
                           state_reg <= trig_readout_pkg::ST_MEASURE; // R7
                           dest_reg <= trig_readout_pkg::DEST_OUTBUF;
                           one_shot_reg <= 1'b1;
                        end
                        `CMD_READ:
                        begin
                           state_reg <= trig_readout_pkg::ST_WAIT_TRIG; // R9
                           dest_reg <= trig_readout_pkg::DEST_OUTBUF; // R12
                           one_shot_reg <= 1'b0;
                        end
                        `CMD_INITIATE:
                        begin
                           state_reg <= trig_readout_pkg::ST_WAIT_TRIG; // R13
                           dest_reg <= trig_readout_pkg::DEST_MEMORY;
                           one_shot_reg <= 1'b0;
                        end
                        `CMD_FETCH:
                           state_reg <= trig_readout_pkg::ST_FETCH; // R14
                        default:
                           state_reg <= trig_readout_pkg::ST_IDLE; // R8
                     endcase
                  end
               end
               trig_readout_pkg::ST_WAIT_TRIG:
               begin
                  // Ignore trigger edges while the destination cannot take a reading
                  if (trig_edge && (dest_reg == trig_readout_pkg::DEST_OUTBUF
                     ? fifo_in_ready : !mem_full)) // R15 R11
                     state_reg <= trig_readout_pkg::ST_MEASURE; // R10
               end
               trig_readout_pkg::ST_MEASURE:
               begin
                  if (i_meas_done)
                  begin
                     rdg_reg <= i_meas_rdg;
                     state_reg <= trig_readout_pkg::ST_DELIVER;
                  end
               end
               trig_readout_pkg::ST_DELIVER:
               begin
                  if (dest_reg == trig_readout_pkg::DEST_MEMORY)
                     state_reg <= trig_readout_pkg::ST_WAIT_TRIG;
                  else if (fifo_in_ready) // R11
                     state_reg <= one_shot_reg ? trig_readout_pkg::ST_IDLE
                        : trig_readout_pkg::ST_WAIT_TRIG;
               end
               trig_readout_pkg::ST_FETCH:
               begin
                  if (mem_empty)
                     state_reg <= trig_readout_pkg::ST_IDLE;
               end
               default:
                  state_reg <= trig_readout_pkg::ST_IDLE;
            endcase
         end
      end
   end
   assign o_state = state_reg;

   // One-cycle start pulse on entry to measuring
   logic meas_active_reg;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         meas_active_reg <= 1'b0;
      else if (i_ce)
         meas_active_reg <= (state_reg == trig_readout_pkg::ST_MEASURE);
   end
   assign o_meas_start = i_ce && !meas_active_reg
      && (state_reg == trig_readout_pkg::ST_MEASURE);

   ////////////////////////////////////////////////////////////////////////
   // Reading memory, first in first out
   trig_readout_pkg::reading_t mem_reg [MEM_DEPTH];
   logic [MAW-1:0] mem_wr_reg;
   logic [MAW-1:0] mem_rd_reg;
   logic [MAW:0] mem_cnt_reg;
   logic mem_push;
   logic mem_pop;

   assign mem_full = (mem_cnt_reg == (MAW+1)'(MEM_DEPTH));
   assign mem_empty = (mem_cnt_reg == '0);
   assign mem_push = i_ce && state_reg == trig_readout_pkg::ST_DELIVER
      && dest_reg == trig_readout_pkg::DEST_MEMORY && !mem_full; // R13
   assign mem_pop = i_ce && state_reg == trig_readout_pkg::ST_FETCH
      && !mem_empty && fifo_in_ready; // R14 R16
   assign o_mem_count = mem_cnt_reg;

   always_ff @(posedge i_clk)
   begin
      if (mem_push)
         mem_reg[mem_wr_reg] <= rdg_reg;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         mem_wr_reg <= '0;
         mem_rd_reg <= '0;
         mem_cnt_reg <= '0;
      end
      else
      begin
         if (mem_push)
            mem_wr_reg <= mem_wr_reg + 1'b1;
         if (mem_pop)
            mem_rd_reg <= mem_rd_reg + 1'b1; // R16
         if (mem_push && !mem_pop)
            mem_cnt_reg <= mem_cnt_reg + 1'b1;
         else if (mem_pop && !mem_push)
            mem_cnt_reg <= mem_cnt_reg - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output buffer
   logic direct_push;
   assign direct_push = state_reg == trig_readout_pkg::ST_DELIVER
      && dest_reg == trig_readout_pkg::DEST_OUTBUF; // R10 R12
   assign fifo_in_valid = direct_push || mem_pop;
   assign fifo_in_data = mem_pop ? mem_reg[mem_rd_reg] : rdg_reg;

   logic [RW-1:0] fifo_out_bits;
   logic fifo_empty;
   sync_fifo #(
      .WIDTH(RW),
      .DEPTH(OUT_DEPTH)
   ) u_out_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_in_valid(fifo_in_valid),
      .i_in_data(fifo_in_data),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_out_valid),
      .o_out_data(fifo_out_bits),
      .i_out_ready(i_out_ready), // R11
      .o_full(),
      .o_empty(fifo_empty)
   );
   assign o_out_rdg = fifo_out_bits;

   ////////////////////////////////////////////////////////////////////////
   // Limit pass/fail pulses on USB contacts
   logic pf_en;
   logic [PCW-1:0] pf_cnt_reg;
   logic pass_n_reg;
   logic fail_n_reg;
   logic out_pop;

   assign pf_en = gpib_sync_reg[1]; // R1 R2 R3
   assign o_usb_en = !pf_en; // R1
   assign out_pop = i_ce && o_out_valid && i_out_ready;

   // Next reading at the buffer head names the line; pulse on its output
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pf_cnt_reg <= '0;
         pass_n_reg <= 1'b1;
         fail_n_reg <= 1'b1;
      end
      else if (i_ce)
      begin
         if (out_pop && pf_en)
         begin
            pf_cnt_reg <= PCW'(PULSE_CYC); // R5
            pass_n_reg <= !o_out_rdg.limit_pass; // R4
            fail_n_reg <= !o_out_rdg.limit_fail; // R4
         end
         else if (pf_cnt_reg > PCW'(1))
            pf_cnt_reg <= pf_cnt_reg - 1'b1;
         else
         begin
            pf_cnt_reg <= '0;
            pass_n_reg <= 1'b1; // R5
            fail_n_reg <= 1'b1;
         end
      end
   end

   assign o_dm_out = pass_n_reg; // R6
   assign o_dp_out = fail_n_reg; // R6
   assign o_dm_oe = pf_en; // R2 R3
   assign o_dp_oe = pf_en;
   assign o_vbus_oe = 1'b0; // R6
endmodule : remote_trigger_readout_ctrl

//--- logic/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready,
   // Status
   output logic o_full,
   output logic o_empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("sync_fifo: DEPTH must be a power of two >= 2");
   end

   assign o_full = (count_reg == (AW+1)'(DEPTH));
   assign o_empty = (count_reg == '0);
   assign o_in_ready = !o_full;
   assign o_out_valid = !o_empty;
   assign o_out_data = mem_reg[rd_ptr_reg];
   assign push = i_ce && i_in_valid && o_in_ready;
   assign pop = i_ce && i_out_ready && o_out_valid;

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= i_in_data;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule : sync_fifo

//--- logic/trig_readout_consts.svh
// Constants for the remote trigger and readout controller
`ifndef TRIG_READOUT_CONSTS_SVH
`define TRIG_READOUT_CONSTS_SVH
`define CLK_FREQ_HZ 10000000
`define PF_PULSE_US 2000
`define PF_TOL_US 100
`define PF_PULSE_CYC ((`PF_PULSE_US * (`CLK_FREQ_HZ / 1000000)))
`define FIFO_DEPTH 32
`define RDG_WIDTH 24
`define MEM_DEPTH 32
`define CMD_W 3
`define CMD_NONE 3'h0
`define CMD_MEASURE 3'h1
`define CMD_CONFIGURE 3'h2
`define CMD_READ 3'h3
`define CMD_INITIATE 3'h4
`define CMD_FETCH 3'h5
`define CMD_ABORT 3'h6
`endif

//--- logic/trig_readout_pkg.sv
// Types for the remote trigger and readout controller
package trig_readout_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_WAIT_TRIG = 3'h1,
      ST_MEASURE = 3'h2,
      ST_DELIVER = 3'h3,
      ST_FETCH = 3'h4
   } trig_state_t;

   typedef enum logic [1:0]
   {
      DEST_OUTBUF = 2'h0,
      DEST_MEMORY = 2'h1
   } dest_t;

   typedef struct packed
   {
      logic [3:0] func;
      logic [3:0] range;
      logic [3:0] resol;
   } meas_cfg_t;

   typedef struct packed
   {
      logic [23:0] value;
      logic limit_pass;
      logic limit_fail;
   } reading_t;
endpackage : trig_readout_pkg

//--- tb/meas_engine_model.sv
// Measurement engine model answering start requests
`timescale 1ns/10ps
module meas_engine_model
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Request from the controller
   input wire logic i_start,
   input wire logic i_slow,
   // Answer toward the controller
   output logic o_done,
   output trig_readout_pkg::reading_t o_rdg
);
   logic busy_reg;
   logic [3:0] wait_reg;
   logic [23:0] cnt_reg;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy_reg <= 1'b0;
         wait_reg <= 4'h0;
         cnt_reg <= 24'h10;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_start)
         begin
            busy_reg <= 1'b1;
            wait_reg <= i_slow ? 4'h6 : 4'h0;
         end
         else if (busy_reg && wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
         else if (busy_reg)
         begin
            busy_reg <= 1'b0;
            o_done <= 1'b1;
            cnt_reg <= cnt_reg + 24'h1;
         end
      end
   end
   // Reading is valid only beside done
   assign o_rdg = o_done ? {cnt_reg, cnt_reg[0], !cnt_reg[0]}
      : {~cnt_reg, 2'h3};
endmodule : meas_engine_model

//--- tb/remote_trigger_readout_ctrl_asserts.sv
// Assertions for the trigger and readout controller
`timescale 1ns/10ps
`include "trig_readout_consts.svh"
module remote_trigger_readout_ctrl_asserts #(
   parameter int PULSE_CYC = 20
)
(
   // Clock and commands
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_cmd_valid,
   input wire logic [`CMD_W-1:0] i_cmd,
   input wire logic o_cmd_ready,
   // Flow and output
   input wire trig_readout_pkg::trig_state_t o_state,
   input wire logic o_meas_start,
   input wire logic o_out_valid,
   input wire trig_readout_pkg::reading_t o_out_rdg,
   input wire logic i_out_ready,
   // Contacts
   input wire logic o_usb_en,
   input wire logic o_dm_out,
   input wire logic o_dm_oe,
   input wire logic o_dp_out,
   input wire logic o_dp_oe,
   input wire logic o_vbus_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic take;
   logic pop;
   logic [31:0] lo_cnt_reg;
   assign take = i_ce && i_cmd_valid && o_cmd_ready;
   assign pop = o_out_valid && i_out_ready;
   // Length of the current low stretch on the pass line
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         lo_cnt_reg <= 32'h0;
      else
         lo_cnt_reg <= o_dm_out ? 32'h0 : lo_cnt_reg + 32'h1;
   end
   ////////////////////////////////////////////////////////////
   a_vbus_float: assert property (o_vbus_oe == 1'b0)
      else $error("bus power contact driven");
   a_usb_swap: assert property (o_usb_en == !o_dm_oe && o_dp_oe == o_dm_oe)
      else $error("usb enable and contact drive disagree");
   a_read_wait: assert property (take && i_cmd == `CMD_READ |=>
      o_state == trig_readout_pkg::ST_WAIT_TRIG)
      else $error("read did not enter wait");
   a_init_wait: assert property (take && i_cmd == `CMD_INITIATE |=>
      o_state == trig_readout_pkg::ST_WAIT_TRIG)
      else $error("initiate did not enter wait");
   a_cfg_idle: assert property (take && i_cmd == `CMD_CONFIGURE |=>
      (o_state == trig_readout_pkg::ST_IDLE && !o_meas_start) [*2])
      else $error("configure started a measurement");
   a_trig_wait: assert property ($rose(o_state ==
      trig_readout_pkg::ST_MEASURE) |->
      $past(o_state) == trig_readout_pkg::ST_WAIT_TRIG
      || $past(take && i_cmd == `CMD_MEASURE))
      else $error("measurement began outside wait");
   a_start_once: assert property (o_meas_start |=> !o_meas_start)
      else $error("start held longer than one cycle");
   a_pop_lines: assert property (o_dm_oe && pop |=>
      o_dm_out == !$past(o_out_rdg.limit_pass) &&
      o_dp_out == !$past(o_out_rdg.limit_fail))
      else $error("pass fail lines do not follow popped reading");
   a_pulse_len: assert property ($rose(o_dm_out) && !$past(pop) |->
      lo_cnt_reg >= PULSE_CYC)
      else $error("pass pulse too short");
   c_read: cover property (take && i_cmd == `CMD_READ);
   c_fetch: cover property (take && i_cmd == `CMD_FETCH);
   c_fail: cover property ($fell(o_dp_out));
endmodule : remote_trigger_readout_ctrl_asserts

bind remote_trigger_readout_ctrl remote_trigger_readout_ctrl_asserts
   #(.PULSE_CYC(PULSE_CYC)) u_chk (.i_clk, .i_rst_n, .i_ce, .i_cmd_valid,
   .i_cmd, .o_cmd_ready, .o_state, .o_meas_start, .o_out_valid, .o_out_rdg,
   .i_out_ready, .o_usb_en, .o_dm_out, .o_dm_oe, .o_dp_out, .o_dp_oe,
   .o_vbus_oe);

//--- tb/remote_trigger_readout_ctrl_test.sv
// Self-checking bench for the trigger and readout controller
`timescale 1ns/10ps
`include "trig_readout_consts.svh"
module remote_trigger_readout_ctrl_test;
   typedef struct packed {logic [2:0] c; logic s; logic m;} row_t;
   logic i_clk = 0, i_rst_n = 0, gsel = 0, cv = 0, trg = 0, ordy = 0;
   logic slow = 0, done, start, ov, rdy, usb, dmo, dmoe, dpo, dpoe, vb;
   logic [2:0] cmd = 3'h0;
   logic [5:0] mcnt;
   logic [23:0] nxt = 24'h11;
   trig_readout_pkg::reading_t mrdg, ordg;
   trig_readout_pkg::trig_state_t st;
   trig_readout_pkg::meas_cfg_t mcfg;
   int fails = 0, checked = 0;
   row_t rows [4] = '{'{`CMD_READ, 1'b0, 1'b0}, '{`CMD_MEASURE, 1'b1, 1'b0},
      '{`CMD_INITIATE, 1'b0, 1'b1}, '{`CMD_READ, 1'b1, 1'b0}};
   always #50 i_clk = ~i_clk;
   remote_trigger_readout_ctrl #(.PULSE_CYC(20)) u_dut (.i_clk, .i_rst_n,
      .i_ce(1'b1), .i_gpib_sel(gsel), .i_cmd_valid(cv), .i_cmd(cmd),
      .i_cmd_cfg(12'h123), .o_cmd_ready(rdy), .i_trigger(trg),
      .o_meas_start(start), .o_meas_cfg(mcfg), .i_meas_done(done),
      .i_meas_rdg(mrdg), .o_out_valid(ov), .o_out_rdg(ordg),
      .i_out_ready(ordy), .o_state(st), .o_mem_count(mcnt), .o_usb_en(usb),
      .o_dm_out(dmo), .o_dm_oe(dmoe), .o_dp_out(dpo), .o_dp_oe(dpoe),
      .o_vbus_oe(vb));
   meas_engine_model u_eng (.i_clk, .i_rst_n, .i_start(start),
      .i_slow(slow), .o_done(done), .o_rdg(mrdg));
   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask : cmp
   task automatic send(logic [2:0] c);
      @(posedge i_clk);
      cv <= 1'b1;
      cmd <= c;
      @(posedge i_clk);
      cv <= 1'b0;
      #1;
   endtask : send
   task automatic trig();
      @(posedge i_clk);
      trg <= 1'b1;
      repeat (3) @(posedge i_clk);
      trg <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : trig
   task automatic waitmem(logic [5:0] n);
      for (int i = 0; i < 100 && mcnt !== n; i++)
      begin
         @(posedge i_clk);
         #1;
      end
      cmp("mem count", {26'h0, n}, {26'h0, mcnt});
   endtask : waitmem
   task automatic pop();
      int i;
      for (i = 0; i < 100 && ov !== 1'b1; i++)
      begin
         @(posedge i_clk);
         #1;
      end
      if (i == 100)
      begin
         fails++;
         conclude();
      end
      cmp("reading", {8'h0, nxt}, {8'h0, ordg.value});
      @(posedge i_clk);
      ordy <= 1'b1;
      @(posedge i_clk);
      ordy <= 1'b0;
      #1;
      cmp("lines", {30'h0, !nxt[0], nxt[0]}, {30'h0, dmo, dpo});
      nxt++;
   endtask : pop
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      cmp("state", 32'h0, {29'h0, st});
      cmp("idle lines", 32'h3, {30'h0, dmo, dpo});
      cmp("usb on", 32'h1, {31'h0, usb});
      cmp("vbus", 32'h0, {31'h0, vb});
      @(posedge i_clk);
      gsel <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      cmp("drive", 32'h3, {30'h0, dmoe, dpoe});
      cmp("usb off", 32'h0, {31'h0, usb});
      for (int r = 0; r < 4; r++)
      begin
         slow = rows[r].s;
         send(rows[r].c);
         cmp("wait", (rows[r].c == `CMD_MEASURE) ? 32'h2 : 32'h1,
            {29'h0, st});
         trig();
         if (rows[r].m)
         begin
            waitmem(6'h1);
            send(`CMD_ABORT);
            send(`CMD_FETCH);
         end
         pop();
         if (rows[r].c == `CMD_READ)
            send(`CMD_ABORT);
         send(`CMD_NONE);
         cmp("end idle", 32'h0, {29'h0, st});
         cmp("mem empty", 32'h0, {26'h0, mcnt});
      end
      slow = 1'b0;
      send(`CMD_CONFIGURE);
      trig();
      cmp("cfg idle", 32'h0, {29'h0, st});
      cmp("cfg no out", 32'h0, {31'h0, ov});
      cmp("cfg applied", 32'h123, {20'h0, mcfg});
      send(`CMD_INITIATE);
      repeat (3) trig();
      waitmem(6'h3);
      send(`CMD_ABORT);
      send(`CMD_FETCH);
      repeat (3) pop();
      send(`CMD_READ);
      repeat (34) trig();
      cmp("read no mem", 32'h0, {26'h0, mcnt});
      repeat (32) pop();
      repeat (10) @(posedge i_clk);
      #1;
      cmp("full stall", 32'h0, {31'h0, ov});
      send(`CMD_ABORT);
      conclude();
   end
endmodule : remote_trigger_readout_ctrl_test
